// >>> src/cish_config_handler.sv
// Boot, forced-default and ASCII configuration handling of the acquisition base
// Notes on behaviour
// - After boot, analog module busy up to 7 s; addressed commands ignored meanwhile.
// - Factory settings are 9600 baud and address 01h in nonvolatile store.
// - Configuration lives in nonvolatile storage and is changed only remotely; slot range and format reset to defaults here.
// - Grounded init terminal at boot selects default settings for the session.
// - Default state: 9600 baud, address 00h, no checksum.
// - Entering the default state leaves the nonvolatile settings untouched.
// - In the default state all settings may change; other commands behave normally.
// - Baud and checksum changes are accepted only in the default state.
// - New baud or checksum is stored and becomes active after next reboot.
// - All other configuration changes act at once, without reset; in the default state an address write goes only to the store.
// - Change command: dollar, address, slot, letter, hex parameters, carriage return.
// - Status request answers bang, address, range code, format code.
// - Range 05 means plus/minus 2.5 V; range 0F means type K thermocouple.
// - Format 00 means engineering units, 50 ms integration, no checksum.
// - Accepted change command answers bang, address, carriage return.
`include "cish_params.svh"
`default_nettype none
module cish_config_handler #(
  parameter int NUM_SLOTS = 8,
  parameter longint BOOT_CYCLES = `CISH_BOOT_CYCLES,
  parameter int BUF_DEPTH = 12
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Forced-default terminal, low when grounded
  input wire logic init_b_i,
  // Characters from the line receiver
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_data_i,
  // Reply characters to the line transmitter
  output logic tx_valid_o,
  output logic [7:0] tx_data_o,
  input wire logic tx_ready_i,
  // Avalon-MM slave
  input wire logic [5:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Working state for the rest of the base
  output cish_pkg::cish_comm_type active_o,
  output logic init_mode_o,
  output logic busy_o,
  output cish_pkg::cish_slot_type [NUM_SLOTS-1:0] slot_cfg_o
);
  import cish_pkg::*;

  localparam logic [7:0] CH_CR = 8'h0D;
  localparam logic [31:0] BOOT_LAST = 32'(BOOT_CYCLES - 64'd1);

  // Hex digit to nibble, top bit flags a valid digit
  function automatic logic [4:0] hex_val(input logic [7:0] c);
    logic [4:0] r;
    r = 5'h00;
    if (c >= 8'h30 && c <= 8'h39) r = {1'b1, 4'(c - 8'h30)};
    else if (c >= 8'h41 && c <= 8'h46) r = {1'b1, 4'(c - 8'h37)};
    else if (c >= 8'h61 && c <= 8'h66) r = {1'b1, 4'(c - 8'h57)};
    return r;
  endfunction : hex_val

  // Nibble to upper case hex character
  function automatic logic [7:0] hex_chr(input logic [3:0] n);
    return (n < 4'hA) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
  endfunction : hex_chr

  logic init_s1_reg, init_s2_reg;
  logic busy_reg, init_mode_reg;
  logic [31:0] boot_cnt_reg;
  cish_comm_type active_reg;
  // Factory contents of the store; reset leaves them alone so a reboot can apply them
  cish_comm_type nv_reg = '{addr: `CISH_FACTORY_ADDR, baud: `CISH_BAUD_9600,
                            cks: 1'b0};
  cish_slot_type [NUM_SLOTS-1:0] slot_reg;
  logic [7:0] buf_reg [BUF_DEPTH];
  logic [3:0] len_reg;
  logic ovf_reg;
  logic [7:0] sum_reg;
  logic [7:0] rep_reg [10];
  logic [3:0] rep_len_reg, rep_idx_reg;
  cish_tx_state_type tx_state_reg;
  logic tx_valid_reg;
  logic [7:0] tx_data_reg;
  logic wait_reg;
  logic [31:0] rdata_reg;
  logic [2:0] err_reg;

  // Init terminal synchroniser; only the second stage is read
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      init_s1_reg <= 1'b1;
      init_s2_reg <= 1'b1;
    end else begin
      init_s1_reg <= init_b_i;
      init_s2_reg <= init_s1_reg;
    end
  end

  // Frame decode, all from the buffered characters before the CR
  wire rx_cr = rx_valid_i && (rx_data_i == CH_CR);
  wire [3:0] body_len = active_reg.cks ? (len_reg - 4'd2) : len_reg;
  wire [4:0] h1 = hex_val(buf_reg[1]);
  wire [4:0] h2 = hex_val(buf_reg[2]);
  wire [4:0] h4 = hex_val(buf_reg[4]);
  wire [4:0] h6 = hex_val(buf_reg[6]);
  wire [4:0] h7 = hex_val(buf_reg[7]);
  wire [4:0] h8 = hex_val(buf_reg[8]);
  wire [4:0] h9 = hex_val(buf_reg[9]);
  wire [4:0] hc1 = hex_val(buf_reg[4'(len_reg - 4'd2)]);
  wire [4:0] hc2 = hex_val(buf_reg[4'(len_reg - 4'd1)]);
  wire head_ok = (buf_reg[0] == 8'h24) && h1[4] && h2[4] && (buf_reg[3] == 8'h53) && h4[4];
  wire is_status = head_ok && (body_len == 4'd6) && (buf_reg[5] == 8'h42);
  wire is_change = head_ok && (body_len == 4'd10) && (buf_reg[5] == 8'h41)
                   && h6[4] && h7[4] && h8[4] && h9[4];
  wire [7:0] cks_calc = sum_reg - buf_reg[4'(len_reg - 4'd2)] - buf_reg[4'(len_reg - 4'd1)];
  wire cks_ok = !active_reg.cks
                || (len_reg >= 4'd2 && hc1[4] && hc2[4] && cks_calc == {hc1[3:0], hc2[3:0]});
  wire addr_hit = ({h1[3:0], h2[3:0]} == active_reg.addr);
  wire slot_ok = {28'h0000_000, h4[3:0]} < 32'(NUM_SLOTS);
  wire frame_ok = rx_cr && !ovf_reg && (is_status || is_change) && slot_ok && addr_hit;
  // Busy and a reply still going out both swallow the frame
  wire accept = frame_ok && cks_ok && !busy_reg && (tx_state_reg == tx_idle);
  wire do_change = accept && is_change;
  wire cks_bad = frame_ok && !cks_ok;
  cish_slot_type sel_slot;
  assign sel_slot = slot_reg[h4[3:0]];

  // Reply image: bang, address, status fields, optional checksum, CR
  logic [7:0] rep_next [10];
  logic [3:0] rep_len_next;
  logic [7:0] rsum;
  always_comb begin
    for (int k = 0; k < 10; k++) rep_next[k] = 8'h00;
    rep_next[0] = 8'h21;
    rep_next[1] = hex_chr(active_reg.addr[7:4]);
    rep_next[2] = hex_chr(active_reg.addr[3:0]);
    rep_len_next = 4'd3;
    if (is_status) begin
      rep_next[3] = hex_chr(sel_slot.range[7:4]);
      rep_next[4] = hex_chr(sel_slot.range[3:0]);
      rep_next[5] = hex_chr(sel_slot.format[7:4]);
      rep_next[6] = hex_chr(sel_slot.format[3:0]);
      rep_len_next = 4'd7;
    end
    rsum = 8'h00;
    for (int k = 0; k < 7; k++) begin
      if (4'(k) < rep_len_next) rsum = rsum + rep_next[k];
    end
    if (active_reg.cks) begin
      rep_next[rep_len_next] = hex_chr(rsum[7:4]);
      rep_next[4'(rep_len_next + 4'd1)] = hex_chr(rsum[3:0]);
      rep_len_next = rep_len_next + 4'd2;
    end
    rep_next[rep_len_next] = CH_CR;
    rep_len_next = rep_len_next + 4'd1;
  end

  // Avalon decode; the answer comes one cycle after the request appears
  wire commit_wr = avs_write_i && !wait_reg;
  wire wr_nv = commit_wr && (avs_address_i == `CISH_OFS_NVCFG);
  wire wr_err = commit_wr && (avs_address_i == `CISH_OFS_ERR);
  wire [5:0] slot_ofs = avs_address_i - `CISH_OFS_SLOT0;
  wire slot_hit = (avs_address_i >= `CISH_OFS_SLOT0) && (slot_ofs[1:0] == 2'b00)
                  && ({28'h0000_000, slot_ofs[5:2]} < 32'(NUM_SLOTS));
  wire [3:0] wr_baud = avs_writedata_i[`CISH_FLD_BAUD_LSB +: 4];
  wire wr_cks = avs_writedata_i[`CISH_FLD_CKS_BIT];
  wire serial_set = (wr_baud != nv_reg.baud) || (wr_cks != nv_reg.cks);
  wire reject = wr_nv && serial_set && !init_mode_reg;
  wire [31:0] status_word = {17'h0_0000, busy_reg, init_mode_reg, active_reg.cks,
                             active_reg.baud, active_reg.addr};
  wire [31:0] nv_word = {19'h0_0000, nv_reg.cks, nv_reg.baud, nv_reg.addr};
  wire [31:0] slot_word = {16'h0000, slot_reg[slot_ofs[5:2]].format,
                           slot_reg[slot_ofs[5:2]].range};
  wire [31:0] rd_mux = (avs_address_i == `CISH_OFS_NVCFG) ? nv_word :
                       (avs_address_i == `CISH_OFS_STATUS) ? status_word :
                       (avs_address_i == `CISH_OFS_ERR) ? {29'h0000_0000, err_reg} :
                       slot_hit ? slot_word : 32'h0000_0000;

  // Bus handshake and sticky error flags; a new event beats a clear
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wait_reg <= 1'b1;
      rdata_reg <= 32'h0000_0000;
      err_reg <= 3'h0;
    end else begin
      wait_reg <= !(wait_reg && (avs_read_i || avs_write_i));
      if (wait_reg && avs_read_i) rdata_reg <= rd_mux;
      err_reg <= (err_reg & ~(wr_err ? avs_writedata_i[2:0] : 3'h0))
                 | {rx_cr && busy_reg, cks_bad, reject};
    end
  end

  // Boot timer, then pick stored or forced-default working settings
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      boot_cnt_reg <= 32'h0000_0000;
      busy_reg <= 1'b1;
      init_mode_reg <= 1'b0;
      active_reg <= '{addr: `CISH_FACTORY_ADDR, baud: `CISH_BAUD_9600, cks: 1'b0};
    end else if (busy_reg) begin
      boot_cnt_reg <= boot_cnt_reg + 32'd1;
      if (boot_cnt_reg == BOOT_LAST) begin
        busy_reg <= 1'b0;
        init_mode_reg <= !init_s2_reg;
        if (!init_s2_reg) active_reg <= '{addr: `CISH_INIT_ADDR, baud: `CISH_BAUD_9600,
                                           cks: 1'b0};
        else active_reg <= nv_reg;
      end
    end else if (wr_nv && !init_mode_reg) begin
      active_reg.addr <= avs_writedata_i[`CISH_FLD_ADDR_LSB +: 8];
    end
  end

  // Nonvolatile image; only bus writes touch it, baud and checksum wait for the next boot
  always_ff @(posedge clk_i) begin
    if (wr_nv) begin
      nv_reg.addr <= avs_writedata_i[`CISH_FLD_ADDR_LSB +: 8];
      if (init_mode_reg) begin
        nv_reg.baud <= wr_baud;
        nv_reg.cks <= wr_cks;
      end
    end
  end

  // Per-slot range and format, written by command or bus with immediate effect
  genvar gi;
  generate
    for (gi = 0; gi < NUM_SLOTS; gi++) begin : g_slot
      wire cmd_hit = do_change && (h4[3:0] == 4'(gi));
      wire bus_hit = commit_wr && slot_hit && (slot_ofs[5:2] == 4'(gi));
      always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          slot_reg[gi] <= '{range: `CISH_DEF_RANGE, format: `CISH_DEF_FORMAT};
        end else if (cmd_hit) begin
          slot_reg[gi] <= '{range: {h6[3:0], h7[3:0]}, format: {h8[3:0], h9[3:0]}};
        end else if (bus_hit) begin
          slot_reg[gi] <= '{range: avs_writedata_i[7:0], format: avs_writedata_i[15:8]};
        end
      end
    end
  endgenerate

  // Receive buffer; overlong frames are dropped whole at the CR
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      len_reg <= 4'd0;
      ovf_reg <= 1'b0;
      sum_reg <= 8'h00;
      for (int k = 0; k < BUF_DEPTH; k++) buf_reg[k] <= 8'h00;
    end else if (rx_cr) begin
      len_reg <= 4'd0;
      ovf_reg <= 1'b0;
      sum_reg <= 8'h00;
    end else if (rx_valid_i) begin
      sum_reg <= sum_reg + rx_data_i;
      if ({28'h0000_000, len_reg} == 32'(BUF_DEPTH)) ovf_reg <= 1'b1;
      else begin
        buf_reg[len_reg] <= rx_data_i;
        len_reg <= len_reg + 4'd1;
      end
    end
  end

  // Reply sender, one character per accepted handshake
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tx_state_reg <= tx_idle;
      tx_valid_reg <= 1'b0;
      tx_data_reg <= 8'h00;
      rep_len_reg <= 4'd0;
      rep_idx_reg <= 4'd0;
      for (int k = 0; k < 10; k++) rep_reg[k] <= 8'h00;
    end else begin
      case (tx_state_reg)
        tx_idle: begin
          if (accept) begin
            rep_reg <= rep_next;
            rep_len_reg <= rep_len_next;
            tx_data_reg <= rep_next[0];
            tx_valid_reg <= 1'b1;
            rep_idx_reg <= 4'd1;
            tx_state_reg <= tx_send;
          end
        end
        tx_send: begin
          if (tx_ready_i) begin
            if (rep_idx_reg == rep_len_reg) begin
              tx_valid_reg <= 1'b0;
              tx_state_reg <= tx_idle;
            end else begin
              tx_data_reg <= rep_reg[rep_idx_reg];
              rep_idx_reg <= rep_idx_reg + 4'd1;
            end
          end
        end
        default: tx_state_reg <= tx_idle;
      endcase
    end
  end

  assign tx_valid_o = tx_valid_reg;
  assign tx_data_o = tx_data_reg;
  assign avs_readdata_o = rdata_reg;
  assign avs_waitrequest_o = wait_reg;
  assign active_o = active_reg;
  assign init_mode_o = init_mode_reg;
  assign busy_o = busy_reg;
  assign slot_cfg_o = slot_reg;

  // Checks on the block's own behaviour
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  property p_busy_silent;
    busy_reg |-> !tx_valid_reg && !accept;
  endproperty
  a_busy_silent: assert property (p_busy_silent) else $error("reply during boot");
  property p_init_defaults;
    init_mode_reg |-> active_reg.addr == 8'h00 && !active_reg.cks
                      && active_reg.baud == `CISH_BAUD_9600;
  endproperty
  a_init_defaults: assert property (p_init_defaults) else $error("bad default set");
  property p_nv_kept;
    $fell(busy_reg) && !$past(wr_nv) |-> $stable(nv_reg);
  endproperty
  a_nv_kept: assert property (p_nv_kept) else $error("store changed at boot");
  property p_reject;
    reject |=> $stable(nv_reg.baud) && $stable(nv_reg.cks) && err_reg[0];
  endproperty
  a_reject: assert property (p_reject) else $error("serial change not refused");
  property p_defer;
    !busy_reg ##1 !busy_reg |-> $stable(active_reg.baud) && $stable(active_reg.cks);
  endproperty
  a_defer: assert property (p_defer) else $error("baud changed before reboot");
  property p_slot_now;
    do_change |=> slot_cfg_o[$past(h4[2:0])] == {$past(h6[3:0]), $past(h7[3:0]),
                                                 $past(h8[3:0]), $past(h9[3:0])};
  endproperty
  a_slot_now: assert property (p_slot_now) else $error("slot not updated");
  property p_foreign_silent;
    rx_cr && !addr_hit && tx_state_reg == tx_idle |=> !tx_valid_reg;
  endproperty
  a_foreign_silent: assert property (p_foreign_silent) else $error("answered other address");
  property p_ack_form;
    do_change |=> tx_valid_reg && tx_data_reg == 8'h21 && rep_reg[3] == 8'h0D
                  || active_reg.cks;
  endproperty
  a_ack_form: assert property (p_ack_form) else $error("bad change answer");
  property p_start_on_cr;
    $rose(tx_valid_reg) |-> $past(rx_cr);
  endproperty
  a_start_on_cr: assert property (p_start_on_cr) else $error("reply without CR");
  c_status: cover property (accept && is_status);
  c_change: cover property (do_change ##[1:40] !tx_valid_reg);
  c_init: cover property ($rose(init_mode_reg));
  c_reject: cover property (reject);
endmodule : cish_config_handler
`default_nettype wire

// >>> src/cish_params.svh
// Offsets, field positions, reset values and timing counts of the config handler
`ifndef CISH_PARAMS_SVH
`define CISH_PARAMS_SVH
`define CISH_OFS_NVCFG 6'h00
`define CISH_OFS_STATUS 6'h04
`define CISH_OFS_ERR 6'h08
`define CISH_OFS_SLOT0 6'h10
`define CISH_FLD_ADDR_LSB 0
`define CISH_FLD_BAUD_LSB 8
`define CISH_FLD_CKS_BIT 12
`define CISH_FLD_INIT_BIT 13
`define CISH_FLD_BUSY_BIT 14
`define CISH_FACTORY_ADDR 8'h01
`define CISH_INIT_ADDR 8'h00
`define CISH_BAUD_9600 4'h6
`define CISH_DEF_RANGE 8'h05
`define CISH_TC_K_RANGE 8'h0F
`define CISH_DEF_FORMAT 8'h00
`define CISH_BOOT_TIME_MS 7000
`define CISH_CLK_KHZ 250000
`define CISH_BOOT_CYCLES (64'd7000 * 64'd250000)
`endif

// >>> src/cish_pkg.sv
// Types shared by the config handler and its users
`default_nettype none
package cish_pkg;
  typedef struct packed {
    logic [7:0] addr;
    logic [3:0] baud;
    logic cks;
  } cish_comm_type;
  typedef struct packed {
    logic [7:0] range;
    logic [7:0] format;
  } cish_slot_type;
  typedef enum {tx_idle, tx_send} cish_tx_state_type;
endpackage : cish_pkg
`default_nettype wire

// >>> tb/cish_config_handler_tb.sv
// Self-checking bench of the config handler with a host model on the serial side
`default_nettype none
module cish_config_handler_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import cish_pkg::*;
  logic clk_i;
  logic rst_b_i;
  logic init_b_i;
  logic rx_valid;
  logic [7:0] rx_data;
  logic tx_valid;
  logic [7:0] tx_data;
  logic tx_ready;
  logic [5:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  cish_comm_type active;
  logic init_mode;
  logic busy;
  cish_slot_type [7:0] slot_cfg;
  int bad_count = 0;
  int n_checks = 0;
  logic [31:0] rd;
  // Short boot count keeps the run brief
  cish_config_handler #(.NUM_SLOTS(8), .BOOT_CYCLES(20), .BUF_DEPTH(12)) u_cish_config_handler (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .init_b_i(init_b_i),
    .rx_valid_i(rx_valid), .rx_data_i(rx_data),
    .tx_valid_o(tx_valid), .tx_data_o(tx_data), .tx_ready_i(tx_ready),
    .avs_address_i(avs_address), .avs_read_i(avs_read), .avs_write_i(avs_write),
    .avs_writedata_i(avs_writedata), .avs_readdata_o(avs_readdata),
    .avs_waitrequest_o(avs_waitrequest), .active_o(active), .init_mode_o(init_mode),
    .busy_o(busy), .slot_cfg_o(slot_cfg));
  cish_host_model u_cish_host_model (
    .clk_i(clk_i), .rx_valid_o(rx_valid), .rx_data_o(rx_data),
    .tx_valid_i(tx_valid), .tx_data_i(tx_data), .tx_ready_o(tx_ready));
  // Clock at 250 MHz
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  // Compare and count
  task automatic check(input logic [95:0] seen, input logic [95:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // Avalon cycle: held until waitrequest is sampled low, read data taken at that edge
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    @(posedge clk_i);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= d;
    // Only the watchdog ends a wait that never comes
    do begin
      @(posedge clk_i);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus
  // Sends a frame and judges the whole reply, an empty one included
  task automatic frame(input string s, input logic [95:0] exp);
    void'(u_cish_host_model.take());
    u_cish_host_model.send(s, 1'b1);
    // Settle time after a change, longer than the shortened boot count
    repeat (60) @(posedge clk_i);
    check(u_cish_host_model.take(), exp);
  endtask : frame
  // Reset with the init terminal set, then wait out the boot interval
  task automatic reboot(input logic init_b);
    init_b_i <= init_b;
    rst_b_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    rst_b_i <= 1'b1;
    @(posedge clk_i);
    while (busy !== 1'b0) begin
      @(posedge clk_i);
    end
  endtask : reboot
  // Reset values, then a frame during the boot interval goes unanswered
  task automatic t_boot;
    rst_b_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    check(busy, 1'b1);
    check(active, {8'h01, 4'h6, 1'b0});
    check(slot_cfg[0], 16'h0500);
    rst_b_i <= 1'b1;
    frame("$01S1B", 96'h0);
    bus(1'b0, 6'h04, 32'h0);
    check(rd, 32'h0000_0601);
    bus(1'b0, 6'h08, 32'h0);
    check(rd, 32'h0000_0004);
    $display("t_boot done");
  endtask : t_boot
  // Status, change, foreign address and a frame held back until its carriage return
  task automatic t_serial;
    frame("$01S1B", {"!010500", 8'h0d});
    frame("$01S1A0F00", {"!01", 8'h0d});
    check(slot_cfg[1], 16'h0F00);
    frame("$02S1B", 96'h0);
    u_cish_host_model.send("$01S1B", 1'b0);
    repeat (30) @(posedge clk_i);
    check(u_cish_host_model.take(), 96'h0);
    frame("", {"!010F00", 8'h0d});
    $display("t_serial done");
  endtask : t_serial
  // Baud and checksum refused outside the default state; unmapped place reads zero
  task automatic t_bus;
    bus(1'b1, 6'h08, 32'h0000_0007);
    bus(1'b1, 6'h00, 32'h0000_1301);
    bus(1'b0, 6'h08, 32'h0);
    check(rd, 32'h0000_0001);
    bus(1'b0, 6'h00, 32'h0);
    check(rd, 32'h0000_0601);
    bus(1'b1, 6'h3C, 32'hFFFF_FFFF);
    bus(1'b0, 6'h3C, 32'h0);
    check(rd, 32'h0);
    bus(1'b0, 6'h14, 32'h0);
    check(rd, 32'h0000_000F);
    bus(1'b1, 6'h18, 32'h0000_030F);
    bus(1'b0, 6'h18, 32'h0);
    check(rd, 32'h0000_030F);
    check(slot_cfg[2], 16'h0F03);
    $display("t_bus done");
  endtask : t_bus
  // Grounded init terminal: default working settings, stored ones kept, changes deferred
  task automatic t_init;
    reboot(1'b0);
    check(active, {8'h00, 4'h6, 1'b0});
    check(init_mode, 1'b1);
    bus(1'b0, 6'h04, 32'h0);
    check(rd, 32'h0000_2600);
    bus(1'b0, 6'h00, 32'h0);
    check(rd, 32'h0000_0601);
    frame("$01S1B", 96'h0);
    frame("$00S1B", {"!000500", 8'h0d});
    bus(1'b1, 6'h08, 32'h0000_0007);
    bus(1'b1, 6'h00, 32'h0000_1401);
    bus(1'b0, 6'h08, 32'h0);
    check(rd, 32'h0);
    bus(1'b0, 6'h04, 32'h0);
    check(rd, 32'h0000_2600);
    $display("t_init done");
  endtask : t_init
  // After the next boot the stored checksum acts both ways, with a stalling host
  task automatic t_cks;
    reboot(1'b1);
    bus(1'b0, 6'h04, 32'h0);
    check(rd, 32'h0000_1401);
    u_cish_host_model.slow_reg <= 1'b1;
    frame("$01S1B4B", {"!01050047", 8'h0d});
    frame("$01S1B00", 96'h0);
    u_cish_host_model.slow_reg <= 1'b0;
    $display("t_cks done");
  endtask : t_cks
  // Counts and verdict
  task automatic test_done;
    $display("checks=%0d mismatches=%0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : test_done
  // Main sequence
  initial begin
    rst_b_i = 1'b0;
    init_b_i = 1'b1;
    avs_address = 6'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    @(posedge clk_i);
    t_boot();
    t_serial();
    t_bus();
    t_init();
    t_cks();
    test_done();
  end
  // Whole run needs some 770 cycles; a hang is cut well beyond that
  initial begin
    repeat (6000) @(posedge clk_i);
    bad_count++;
    test_done();
  end
endmodule : cish_config_handler_tb
`default_nettype wire

// >>> tb/cish_host_model.sv
// Host model that sends ASCII frames to the handler and collects its replies
`default_nettype none
module cish_host_model (
  // Clock
  input wire logic clk_i,
  // Characters towards the handler
  output logic rx_valid_o,
  output logic [7:0] rx_data_o,
  // Reply characters from the handler
  input wire logic tx_valid_i,
  input wire logic [7:0] tx_data_i,
  output logic tx_ready_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic slow_reg = 1'b0;
  logic [7:0] reply_q[$];
  // Quiet line at time zero
  initial begin
    rx_valid_o = 1'b0;
    rx_data_o = 8'h00;
    tx_ready_o = 1'b1;
  end
  // Slow mode takes a reply char only every other cycle, to stretch the handshake
  always @(posedge clk_i) begin
    tx_ready_o <= slow_reg ? ~tx_ready_o : 1'b1;
    if (tx_valid_i && tx_ready_o) begin
      reply_q.push_back(tx_data_i);
    end
  end
  // One char a cycle, closed by a carriage return when with_cr is set
  task automatic send(input string s, input bit with_cr);
    for (int i = 0; i < s.len(); i++) begin
      @(posedge clk_i);
      rx_valid_o <= 1'b1;
      rx_data_o <= s[i];
    end
    if (with_cr) begin
      @(posedge clk_i);
      rx_valid_o <= 1'b1;
      rx_data_o <= 8'h0d;
    end
    @(posedge clk_i);
    rx_valid_o <= 1'b0;
    rx_data_o <= ~rx_data_o;  // Stale data would hide a decoder that ignores the strobe
  endtask : send
  // Packs all replies seen so far, oldest char highest, and empties the queue
  function automatic logic [95:0] take();
    logic [95:0] v;
    v = '0;
    while (reply_q.size() > 0) v = {v[87:0], reply_q.pop_front()};
    return v;
  endfunction : take
endmodule : cish_host_model
`default_nettype wire
